// *** ptp_top.sv ***
// pulse-train position front end: settings, in-position, torque clamp, encoder re-output
`timescale 1ns/1ps
`default_nettype none
`include "ptp_params.svh"
module ptp_top (
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // command pulse pins
  input wire logic cmd_pin_a,
  input wire logic cmd_pin_b,
  // position error from the control loop
  input wire logic signed [31:0] pos_err_cmd,
  input wire logic signed [31:0] pos_err_enc,
  // torque request, full scale 1000, ccw positive
  input wire logic signed [15:0] torque_req,
  // motor encoder count pulses
  input wire logic motor_step_up,
  input wire logic motor_step_dn,
  // outputs
  output logic in_position_flag,
  output logic signed [15:0] torque_out,
  output logic cmd_ccw_step,
  output logic cmd_cw_step,
  output logic enc_a,
  output logic enc_b
);
  localparam logic [5:0] ENC_GAP = 6'(`PTP_ENC_GAP_CYC);

  ptp_pkg::ptp_bus_t bus; // bundled register request
  ptp_pkg::ptp_latched_t pend_ff; // written, not yet in use
  ptp_pkg::ptp_latched_t act_ff; // in use
  logic [15:0] inp_range_ff; // in-position range
  logic pos_unit_ff; // 1: range in encoder pulses
  logic [6:0] fwd_tlim_ff; // percent
  logic [6:0] rev_tlim_ff; // percent
  logic signed [31:0] cmd_pos_ff; // command position, ccw positive
  logic [31:0] rdata_ff;
  logic in_pos_ff;
  logic signed [15:0] torque_ff;
  logic ccw_ff;
  logic cw_ff;
  logic dec_fwd; // decoded forward pulse
  logic dec_rev; // decoded reverse pulse
  logic apply_req; // apply written this cycle

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // address match, used by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // torque limit write saturates at 100 percent
  function automatic logic [6:0] lim_pct(input logic [31:0] d);
    lim_pct = (d > 32'h0000_0064) ? `PTP_RST_TLIM : d[6:0];
  endfunction : lim_pct

  // live settings, used at once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      inp_range_ff <= `PTP_RST_INP_RANGE;
      pos_unit_ff <= 1'b0;
      fwd_tlim_ff <= `PTP_RST_TLIM;
      rev_tlim_ff <= `PTP_RST_TLIM;
    end else if (bus.wr) begin
      if (hit(bus.addr, `PTP_OFF_INP_RANGE)) begin
        inp_range_ff <= bus.wdata[15:0];
      end else if (hit(bus.addr, `PTP_OFF_POS_UNIT)) begin
        pos_unit_ff <= bus.wdata[0];
      end else if (hit(bus.addr, `PTP_OFF_FWD_TLIM)) begin
        fwd_tlim_ff <= lim_pct(bus.wdata);
      end else if (hit(bus.addr, `PTP_OFF_REV_TLIM)) begin
        rev_tlim_ff <= lim_pct(bus.wdata);
      end
    end
  end

  // pending copies of settings that wait for apply
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_ff.pulse_form <= `PTP_RST_PULSE_FORM;
      pend_ff.dir_sel <= 1'b0;
      pend_ff.enc_count <= `PTP_RST_ENC_COUNT;
      pend_ff.enc_den <= `PTP_RST_ENC_DEN;
      pend_ff.enc_mode <= 2'h0;
    end else if (bus.wr) begin
      if (hit(bus.addr, `PTP_OFF_PULSE_FORM)) begin
        pend_ff.pulse_form <= bus.wdata[11:0];
      end else if (hit(bus.addr, `PTP_OFF_DIR_SEL)) begin
        pend_ff.dir_sel <= bus.wdata[0];
      end else if (hit(bus.addr, `PTP_OFF_ENC_COUNT)) begin
        pend_ff.enc_count <= bus.wdata[15:0];
      end else if (hit(bus.addr, `PTP_OFF_ENC_DEN)) begin
        pend_ff.enc_den <= bus.wdata[15:0];
      end else if (hit(bus.addr, `PTP_OFF_ENC_MODE)) begin
        pend_ff.enc_mode <= bus.wdata[`PTP_EMODE_LSB +: 2];
      end
    end
  end

  assign apply_req = bus.wr & hit(bus.addr, `PTP_OFF_APPLY) & bus.wdata[0];

  // active copies change only at reset or apply, standing in for a power cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      act_ff.pulse_form <= `PTP_RST_PULSE_FORM;
      act_ff.dir_sel <= 1'b0;
      act_ff.enc_count <= `PTP_RST_ENC_COUNT;
      act_ff.enc_den <= `PTP_RST_ENC_DEN;
      act_ff.enc_mode <= 2'h0;
    end else if (apply_req) begin
      act_ff <= pend_ff;
    end
  end

  // read path, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (!bus.rd) begin
      rdata_ff <= 32'h0000_0000;
    end else if (hit(bus.addr, `PTP_OFF_INP_RANGE)) begin
      rdata_ff <= {16'h0000, inp_range_ff};
    end else if (hit(bus.addr, `PTP_OFF_POS_UNIT)) begin
      rdata_ff <= {31'h0000_0000, pos_unit_ff};
    end else if (hit(bus.addr, `PTP_OFF_FWD_TLIM)) begin
      rdata_ff <= {25'h000_0000, fwd_tlim_ff};
    end else if (hit(bus.addr, `PTP_OFF_REV_TLIM)) begin
      rdata_ff <= {25'h000_0000, rev_tlim_ff};
    end else if (hit(bus.addr, `PTP_OFF_PULSE_FORM)) begin
      rdata_ff <= {20'h0_0000, pend_ff.pulse_form};
    end else if (hit(bus.addr, `PTP_OFF_DIR_SEL)) begin
      rdata_ff <= {31'h0000_0000, pend_ff.dir_sel};
    end else if (hit(bus.addr, `PTP_OFF_ENC_COUNT)) begin
      rdata_ff <= {16'h0000, pend_ff.enc_count};
    end else if (hit(bus.addr, `PTP_OFF_ENC_DEN)) begin
      rdata_ff <= {16'h0000, pend_ff.enc_den};
    end else if (hit(bus.addr, `PTP_OFF_ENC_MODE)) begin
      rdata_ff <= {26'h000_0000, pend_ff.enc_mode, 4'h0};
    end else if (hit(bus.addr, `PTP_OFF_STATUS)) begin
      // status: flag, pending differs from active, active form and mode
      rdata_ff <= {14'h0000, act_ff.enc_mode, act_ff.dir_sel, act_ff.pulse_form,
                   1'b0, (pend_ff != act_ff), in_pos_ff};
    end else if (hit(bus.addr, `PTP_OFF_CMD_POS)) begin
      rdata_ff <= cmd_pos_ff;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // command pulse decode runs on the latched form only
  ptp_cmd_decoder u_dec (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_a(cmd_pin_a),
    .pin_b(cmd_pin_b),
    .form_cfg(act_ff.pulse_form),
    .fwd_pulse(dec_fwd),
    .rev_pulse(dec_rev)
  );

  // direction mapping and command position count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ccw_ff <= 1'b0;
      cw_ff <= 1'b0;
      cmd_pos_ff <= 32'sh0000_0000;
    end else begin
      // selection 1 swaps both directions
      ccw_ff <= act_ff.dir_sel ? dec_rev : dec_fwd;
      cw_ff <= act_ff.dir_sel ? dec_fwd : dec_rev;
      if (ccw_ff) begin
        cmd_pos_ff <= cmd_pos_ff + 32'sh0000_0001;
      end else if (cw_ff) begin
        cmd_pos_ff <= cmd_pos_ff - 32'sh0000_0001;
      end
    end
  end

  // in-position check on the error magnitude in the chosen unit
  logic signed [31:0] err_sel;
  logic [31:0] err_mag;
  always_comb begin
    err_sel = pos_unit_ff ? pos_err_enc : pos_err_cmd;
    err_mag = err_sel[31] ? 32'(-err_sel) : 32'(err_sel);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_pos_ff <= 1'b0;
    end else begin
      in_pos_ff <= (err_mag <= {16'h0000, inp_range_ff});
    end
  end

  // torque clamp: positive torque covers ccw drive and cw regeneration
  logic signed [16:0] fwd_cap; // fwd_torque_cap in request units
  logic signed [16:0] rev_cap; // rev_torque_cap in request units
  logic signed [16:0] treq;
  always_comb begin
    fwd_cap = 17'(fwd_tlim_ff * `PTP_TORQUE_SCALE);
    rev_cap = 17'(rev_tlim_ff * `PTP_TORQUE_SCALE);
    treq = 17'(torque_req);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      torque_ff <= 16'sh0000;
    end else if (treq > fwd_cap) begin
      torque_ff <= fwd_cap[15:0];
    end else if (treq < -rev_cap) begin
      torque_ff <= 16'(-rev_cap);
    end else begin
      // a zero limit leaves zero as the only value on its side of the window
      torque_ff <= torque_req;
    end
  end

  // encoder output scaling: edges per motor count is num/den
  logic [39:0] sc_num;
  logic [39:0] sc_den;
  logic [15:0] cnt_eff; // count, zero taken as one
  logic [15:0] den_eff; // denominator, zero taken as one
  always_comb begin
    cnt_eff = (act_ff.enc_count == 16'h0000) ? 16'h0001 : act_ff.enc_count;
    den_eff = (act_ff.enc_den == 16'h0000) ? 16'h0001 : act_ff.enc_den;
    case (act_ff.enc_mode)
      2'h1: begin // division ratio: resolution / count edges per rev
        sc_num = 40'h00_0000_0001;
        sc_den = {24'h00_0000, cnt_eff};
      end
      2'h3: begin // gear: resolution * count / den edges per rev
        sc_num = {24'h00_0000, cnt_eff};
        sc_den = {24'h00_0000, den_eff};
      end
      default: begin // count is edges per rev directly
        sc_num = {24'h00_0000, cnt_eff};
        sc_den = `PTP_MOTOR_RES;
      end
    endcase
  end

  // fractional accumulator turns motor counts into output edges
  logic signed [40:0] acc_ff;
  logic signed [40:0] nxt_acc;
  logic signed [31:0] backlog_ff; // edges owed, signed
  logic signed [31:0] nxt_backlog;
  logic [5:0] gap_ff; // cycles until next edge allowed
  logic [1:0] phase_ff; // quadrature step
  logic edge_go;
  always_comb begin
    nxt_acc = acc_ff;
    if (motor_step_up && !motor_step_dn) begin
      nxt_acc = acc_ff + $signed({1'b0, sc_num});
    end else if (motor_step_dn && !motor_step_up) begin
      nxt_acc = acc_ff - $signed({1'b0, sc_num});
    end
    nxt_backlog = backlog_ff;
    // one edge released per cycle; large gear ratios drain over several cycles
    if (nxt_acc >= $signed({1'b0, sc_den})) begin
      nxt_acc = nxt_acc - $signed({1'b0, sc_den});
      nxt_backlog = nxt_backlog + 32'sh0000_0001;
    end else if (nxt_acc <= -$signed({1'b0, sc_den})) begin
      nxt_acc = nxt_acc + $signed({1'b0, sc_den});
      nxt_backlog = nxt_backlog - 32'sh0000_0001;
    end
    edge_go = (gap_ff == 6'h00) && (backlog_ff != 32'sh0000_0000);
    if (edge_go) begin
      nxt_backlog = backlog_ff[31] ? nxt_backlog + 32'sh0000_0001
                                   : nxt_backlog - 32'sh0000_0001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_ff <= 41'sh000_0000_0000;
      backlog_ff <= 32'sh0000_0000;
    end else if (apply_req) begin
      // new scaling starts from a clean fraction
      acc_ff <= 41'sh000_0000_0000;
      backlog_ff <= 32'sh0000_0000;
    end else begin
      acc_ff <= nxt_acc;
      backlog_ff <= nxt_backlog;
    end
  end

  // edge pacing holds the four-edge rate at or below the maximum
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_ff <= 6'h00;
    end else if (edge_go) begin
      gap_ff <= ENC_GAP - 6'h01;
    end else if (gap_ff != 6'h00) begin
      gap_ff <= gap_ff - 6'h01;
    end
  end

  // quadrature stepping: four steps make one a/b cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_ff <= 2'h0;
      enc_a <= 1'b0;
      enc_b <= 1'b0;
    end else begin
      if (edge_go) begin
        phase_ff <= backlog_ff[31] ? phase_ff - 2'h1 : phase_ff + 2'h1;
      end
      // a leads b while counting up
      enc_a <= phase_ff[0] ^ phase_ff[1];
      enc_b <= phase_ff[1];
    end
  end

  assign reg_rdata = rdata_ff;
  assign in_position_flag = in_pos_ff;
  assign torque_out = torque_ff;
  assign cmd_ccw_step = ccw_ff;
  assign cmd_cw_step = cw_ff;
endmodule : ptp_top
`default_nettype wire

// *** ptp_params.svh ***
// constants for the pulse-train position front end: offsets, fields, resets, timing
`ifndef PTP_PARAMS_SVH
`define PTP_PARAMS_SVH
// Summary of operation
// - in-position flag when error within range
// - unit select switches range to encoder pulses
// - forward limit clamps positive torque, zero none
// - reverse limit clamps negative torque, zero none
// - three pulse forms, either logic polarity
// - quadrature form counts all four edges
// - filter field picks maximum accepted rate
// - starred settings apply only after apply
// - direction selection swaps ccw and cw mapping
// - each phase gives half of output count
// - output edge rate capped at 4.6 Mpps
// - output mode: direct count, division ratio or gear
// - gear denominator scales output with count
// - division mode divides 131072 by count
// - gear mode multiplies resolution by ratio
// - denominator zero is taken as one

// register offsets (byte addresses)
`define PTP_OFF_INP_RANGE 8'h00
`define PTP_OFF_POS_UNIT 8'h04
`define PTP_OFF_FWD_TLIM 8'h08
`define PTP_OFF_REV_TLIM 8'h0C
`define PTP_OFF_PULSE_FORM 8'h10
`define PTP_OFF_DIR_SEL 8'h14
`define PTP_OFF_ENC_COUNT 8'h18
`define PTP_OFF_ENC_DEN 8'h1C
`define PTP_OFF_ENC_MODE 8'h20
`define PTP_OFF_APPLY 8'h24
`define PTP_OFF_STATUS 8'h28
`define PTP_OFF_CMD_POS 8'h2C
// pulse form field: form digit, logic digit, filter digit
`define PTP_FORM_LSB 0
`define PTP_LOGIC_LSB 4
`define PTP_FILT_LSB 8
// encoder mode field sits in the middle digit
`define PTP_EMODE_LSB 4
// reset values
`define PTP_RST_INP_RANGE 16'h0064
`define PTP_RST_TLIM 7'h64
`define PTP_RST_PULSE_FORM 12'h000
`define PTP_RST_ENC_COUNT 16'h0FA0
`define PTP_RST_ENC_DEN 16'h0001
// motor resolution, counts per revolution
`define PTP_MOTOR_RES 40'h00_0002_0000
// torque units: request full scale 1000, limit in percent
`define PTP_TORQUE_SCALE 16'h000A
// timing
`define PTP_CLK_MHZ 125
`define PTP_ENC_MAX_KPPS 4600
`define PTP_ENC_GAP_CYC ((`PTP_CLK_MHZ * 1000 + `PTP_ENC_MAX_KPPS - 1) / `PTP_ENC_MAX_KPPS)
`define PTP_FILT0_NS 80
`define PTP_FILT1_NS 200
`define PTP_FILT2_NS 500
`define PTP_NS2CYC(ns) (((ns) * `PTP_CLK_MHZ + 999) / 1000)
`endif

// *** ptp_pkg.sv ***
// types shared by the pulse-train position front end
`default_nettype none
package ptp_pkg;
  // command pulse input forms
  typedef enum logic [1:0] {
    PTP_FORM_FWD_REV,
    PTP_FORM_PULSE_SIGN,
    PTP_FORM_QUAD
  } ptp_form_t;
  // encoder output scaling modes
  typedef enum logic [1:0] {
    PTP_EMODE_DIRECT,
    PTP_EMODE_DIVIDE,
    PTP_EMODE_SAME,
    PTP_EMODE_GEAR
  } ptp_emode_t;
  // settings that only take effect at apply
  typedef struct packed {
    logic [11:0] pulse_form;
    logic dir_sel;
    logic [15:0] enc_count;
    logic [15:0] enc_den;
    logic [1:0] enc_mode;
  } ptp_latched_t;
  // software register port
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ptp_bus_t;
endpackage : ptp_pkg
`default_nettype wire

// *** ptp_cmd_decoder.sv ***
// command pulse decoder: polarity, noise filter and form decode
`timescale 1ns/1ps
`default_nettype none
`include "ptp_params.svh"
module ptp_cmd_decoder (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic [11:0] form_cfg,
  output logic fwd_pulse,
  output logic rev_pulse
);
  logic [1:0] raw; // polarity corrected inputs
  logic [1:0] clean_ff; // filtered levels
  logic [1:0] prev_ff; // previous filtered levels
  logic [5:0] filt_len; // stable cycles needed
  logic [1:0] form; // selected form
  logic [1:0] rise;

  assign form = form_cfg[`PTP_FORM_LSB +: 2];
  // negative logic inverts both lines before anything else
  assign raw = {pin_b, pin_a} ^ {2{form_cfg[`PTP_LOGIC_LSB]}};

  // lower rate ranges reject wider glitches
  always_comb begin
    case (form_cfg[`PTP_FILT_LSB +: 2])
      2'h1: filt_len = 6'(`PTP_NS2CYC(`PTP_FILT1_NS));
      2'h2: filt_len = 6'(`PTP_NS2CYC(`PTP_FILT2_NS));
      default: filt_len = 6'(`PTP_NS2CYC(`PTP_FILT0_NS));
    endcase
  end

  // one stability filter per line
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      logic [5:0] stab_ff; // cycles the line differed from clean
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          stab_ff <= 6'h00;
          clean_ff[gi] <= 1'b0;
        end else if (raw[gi] == clean_ff[gi]) begin
          stab_ff <= 6'h00;
        end else if (stab_ff + 6'h01 >= filt_len) begin
          // level held long enough, accept it
          clean_ff[gi] <= raw[gi];
          stab_ff <= 6'h00;
        end else begin
          stab_ff <= stab_ff + 6'h01;
        end
      end
    end
  endgenerate

  assign rise = clean_ff & ~prev_ff;

  // edge detection and form decode, pulses are registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_ff <= 2'h0;
      fwd_pulse <= 1'b0;
      rev_pulse <= 1'b0;
    end else begin
      prev_ff <= clean_ff;
      fwd_pulse <= 1'b0;
      rev_pulse <= 1'b0;
      case (form)
        2'h0: begin // separate forward and reverse trains
          fwd_pulse <= rise[0] & ~rise[1];
          rev_pulse <= rise[1] & ~rise[0];
        end
        2'h1: begin // pulse on a, sign on b
          fwd_pulse <= rise[0] & ~clean_ff[1];
          rev_pulse <= rise[0] & clean_ff[1];
        end
        default: begin // quadrature, every edge counts
          if (clean_ff != prev_ff && ^(clean_ff ^ prev_ff)) begin
            // a leads b when new b equals old a
            fwd_pulse <= (clean_ff[1] == prev_ff[0]);
            rev_pulse <= (clean_ff[1] != prev_ff[0]);
          end
        end
      endcase
    end
  end
endmodule : ptp_cmd_decoder
`default_nettype wire

// *** ptp_top_assertions.sv ***
// checker for the pulse-train position front end ports
`timescale 1ns/1ps
`default_nettype none
`include "ptp_params.svh"
module ptp_top_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cmd_pin_a,
  input wire logic cmd_pin_b,
  input wire logic signed [31:0] pos_err_cmd,
  input wire logic signed [31:0] pos_err_enc,
  input wire logic signed [15:0] torque_req,
  input wire logic in_position_flag,
  input wire logic signed [15:0] torque_out,
  input wire logic cmd_ccw_step,
  input wire logic cmd_cw_step,
  input wire logic enc_a,
  input wire logic enc_b
);
  localparam int GAP = `PTP_ENC_GAP_CYC;
  logic [15:0] range_ff; // shadow of the range
  logic unit_ff; // shadow of the unit select
  logic [6:0] fwd_ff; // shadow limits, percent
  logic [6:0] rev_ff;
  logic [1:0] enc_q; // last encoder pins
  logic [1:0] pin_q; // last command pins
  logic [7:0] enc_age; // cycles since an encoder edge
  logic [7:0] pin_age; // cycles since a pin change
  logic enc_mv;
  logic wi; // expected flag
  int es;
  int lf;
  int lr;
  int tq; // expected clamped torque
  assign enc_mv = {enc_a, enc_b} != enc_q;
  assign es = unit_ff ? pos_err_enc : pos_err_cmd;
  assign wi = (es < 0 ? -es : es) <= int'(range_ff);
  assign lf = int'(fwd_ff) * 10;
  assign lr = -(int'(rev_ff) * 10);
  assign tq = torque_req > lf ? lf : (torque_req < lr ? lr : torque_req);
  // settings track writes; limits above full scale saturate
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      range_ff <= `PTP_RST_INP_RANGE;
      unit_ff <= 1'b0;
      fwd_ff <= `PTP_RST_TLIM;
      rev_ff <= `PTP_RST_TLIM;
    end else if (reg_wr) begin
      if (reg_addr == `PTP_OFF_INP_RANGE) range_ff <= reg_wdata[15:0];
      if (reg_addr == `PTP_OFF_POS_UNIT) unit_ff <= reg_wdata[0];
      if (reg_addr == `PTP_OFF_FWD_TLIM) fwd_ff <= reg_wdata > 32'h64 ? 7'h64 : reg_wdata[6:0];
      if (reg_addr == `PTP_OFF_REV_TLIM) rev_ff <= reg_wdata > 32'h64 ? 7'h64 : reg_wdata[6:0];
    end
  end
  // edge ages saturate so a command step with no pin change since reset still fails
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enc_q <= 2'h0;
      pin_q <= 2'h0;
      enc_age <= 8'hFF;
      pin_age <= 8'hFF;
    end else begin
      enc_q <= {enc_a, enc_b};
      pin_q <= {cmd_pin_a, cmd_pin_b};
      enc_age <= enc_mv ? 8'h00 : (enc_age == 8'hFF ? enc_age : enc_age + 8'h01);
      pin_age <= {cmd_pin_a, cmd_pin_b} != pin_q ? 8'h00 : (pin_age == 8'hFF ? pin_age : pin_age + 8'h01);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_quiet;
    !reg_rd;
  endsequence
  sequence s_awake;
    !$past(rst);
  endsequence
  property p_rd_idle;
    s_quiet |=> reg_rdata == 32'h0;
  endproperty
  AST_INP_CMD: assert property (s_awake ##0 !$past(unit_ff) |-> in_position_flag == $past(wi))
    else $error("in-position flag wrong for command units");
  AST_INP_ENC: assert property (s_awake ##0 $past(unit_ff) |-> in_position_flag == $past(wi))
    else $error("in-position flag wrong for encoder units");
  AST_TQ_FWD: assert property (s_awake ##0 $past(torque_req) >= 0 |-> torque_out == $past(tq))
    else $error("forward torque clamp wrong");
  AST_TQ_REV: assert property (s_awake ##0 $past(torque_req) < 0 |-> torque_out == $past(tq))
    else $error("reverse torque clamp wrong");
  AST_STEP_LAT: assert property (cmd_ccw_step || cmd_cw_step |-> pin_age >= 8'h08 && pin_age <= 8'h46)
    else $error("command step without a filtered pin change");
  AST_STEP_EXCL: assert property (!(cmd_ccw_step && cmd_cw_step))
    else $error("both rotation steps at once");
  AST_ENC_ONE: assert property (enc_mv |-> enc_a == enc_q[1] || enc_b == enc_q[0])
    else $error("both encoder phases moved together");
  AST_ENC_GAP: assert property (enc_mv |-> enc_age >= GAP - 1)
    else $error("encoder edges too close");
  AST_RD_IDLE: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
endmodule : ptp_top_assertions
bind ptp_top ptp_top_assertions chk (.*);
`default_nettype wire

// *** ptp_ctrl_model.sv ***
// positioning controller model driving the command pulse lines
`timescale 1ns/1ps
`default_nettype none
module ptp_ctrl_model (
  input wire logic clk_sys,
  output logic pin_a,
  output logic pin_b
);
  int ph = 0; // quadrature phase index
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // park both lines idle; quadrature restarts at phase zero
  task automatic park(input logic neg);
    @(posedge clk_sys);
    pin_a <= neg;
    pin_b <= neg;
    ph = 0;
  endtask : park
  // one level change held for hold cycles
  task automatic put(input logic a, input logic b, input int hold);
    @(posedge clk_sys);
    pin_a <= a;
    pin_b <= b;
    repeat (hold) @(posedge clk_sys);
  endtask : put
  // n counts; hold is picked to outlast the filter range in use
  task automatic send(input logic [1:0] form, input logic neg, input logic fwd, input int n, input int hold);
    if (form == 2'h1) put(neg, !fwd ^ neg, hold); // sign settles first
    for (int i = 0; i < n; i++) begin
      if (form == 2'h2) begin // one edge per count, a leads forward
        ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
        put((ph == 1 || ph == 2) ^ neg, (ph >= 2) ^ neg, hold);
      end else if (form == 2'h1) begin // pulse on a, sign on b
        put(!neg, !fwd ^ neg, hold);
        put(neg, !fwd ^ neg, hold);
      end else begin // separate forward and reverse trains
        put(fwd ^ neg, !fwd ^ neg, hold);
        put(neg, neg, hold);
      end
    end
  endtask : send
endmodule : ptp_ctrl_model
`default_nettype wire

// *** ptp_top_test.sv ***
// self-checking bench for the pulse-train position front end
`timescale 1ns/1ps
`default_nettype none
`include "ptp_params.svh"
module ptp_top_test;
  logic clk_sys, rst, reg_wr, reg_rd, motor_step_up, motor_step_dn, cmd_pin_a, cmd_pin_b;
  logic in_position_flag, cmd_ccw_step, cmd_cw_step, enc_a, enc_b;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic signed [31:0] pos_err_cmd, pos_err_enc;
  logic signed [15:0] torque_req, torque_out;
  int err_total, n_tests, n_ccw, n_cw, n_ea, n_eb;
  ptp_top uut (.*);
  ptp_ctrl_model ctl (.clk_sys(clk_sys), .pin_a(cmd_pin_a), .pin_b(cmd_pin_b));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // steps stand one cycle, so the falling edge sees each once
  always @(negedge clk_sys) begin
    if (cmd_ccw_step === 1'b1) n_ccw++;
    if (cmd_cw_step === 1'b1) n_cw++;
  end
  always @(enc_a) n_ea++;
  always @(enc_b) n_eb++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask = '1);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    check(reg_rdata & mask, exp);
  endtask : rdc
  // let a level input pass its output flop
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle
  // apply a pulse form, then 4 forward and 2 reverse counts
  task automatic pulses(input logic [11:0] f, input logic d, input int hold);
    wr(`PTP_OFF_PULSE_FORM, {20'h0, f});
    wr(`PTP_OFF_DIR_SEL, {31'h0, d});
    ctl.park(f[4]);
    wr(`PTP_OFF_APPLY, 32'h1);
    repeat (100) @(posedge clk_sys);
    n_ccw = 0;
    n_cw = 0;
    ctl.send(f[1:0], f[4], 1'b1, 4, hold);
    ctl.send(f[1:0], f[4], 1'b0, 2, hold);
    repeat (100) @(posedge clk_sys);
    check(n_ccw, d ? 32'h2 : 32'h4);
    check(n_cw, d ? 32'h4 : 32'h2);
  endtask : pulses
  // motor steps one way, spaced wider than the output edge gap
  task automatic enc(input logic [1:0] m, input logic [15:0] c, input logic [15:0] dv, input int n,
    input logic dn, input int exp);
    wr(`PTP_OFF_ENC_MODE, {26'h0, m, 4'h0});
    wr(`PTP_OFF_ENC_COUNT, {16'h0, c});
    wr(`PTP_OFF_ENC_DEN, {16'h0, dv});
    wr(`PTP_OFF_APPLY, 32'h1);
    repeat (10) @(posedge clk_sys);
    n_ea = 0;
    n_eb = 0;
    for (int i = 0; i < n; i++) begin
      motor_step_up <= !dn;
      motor_step_dn <= dn;
      @(posedge clk_sys);
      motor_step_up <= 1'b0;
      motor_step_dn <= 1'b0;
      repeat (30) @(posedge clk_sys);
    end
    repeat (300) @(posedge clk_sys);
    check(n_ea + n_eb, exp);
    check(n_ea, exp / 2);
  endtask : enc
  task automatic end_sim;
    $display("mismatches %0d, comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, pos_err_cmd, pos_err_enc, torque_req, motor_step_up, motor_step_dn} = '0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // defaults out of reset, then an unmapped place
    rdc(`PTP_OFF_INP_RANGE, 32'h64);
    rdc(`PTP_OFF_FWD_TLIM, 32'h64);
    rdc(`PTP_OFF_REV_TLIM, 32'h64);
    rdc(`PTP_OFF_PULSE_FORM, 32'h0);
    rdc(`PTP_OFF_ENC_COUNT, 32'hFA0);
    rdc(`PTP_OFF_ENC_DEN, 32'h1);
    rdc(8'h3C, 32'h0);
    // torque clamp, zero limit and saturating write
    wr(`PTP_OFF_FWD_TLIM, 32'h32);
    wr(`PTP_OFF_REV_TLIM, 32'h0);
    torque_req <= 16'sh0320;
    settle();
    check(torque_out, 32'h1F4);
    @(posedge clk_sys);
    torque_req <= -16'sh012C;
    settle();
    check(torque_out, 32'h0);
    wr(`PTP_OFF_FWD_TLIM, 32'h78);
    rdc(`PTP_OFF_FWD_TLIM, 32'h64);
    // in-position at the range edge, both signs and both units
    wr(`PTP_OFF_INP_RANGE, 32'h5);
    pos_err_cmd <= -32'sh5;
    settle();
    check(in_position_flag, 32'h1);
    @(posedge clk_sys);
    pos_err_cmd <= 32'sh6;
    settle();
    check(in_position_flag, 32'h0);
    wr(`PTP_OFF_POS_UNIT, 32'h1);
    pos_err_enc <= -32'sh3;
    settle();
    check(in_position_flag, 32'h1);
    wr(`PTP_OFF_POS_UNIT, 32'h0);
    // a pending form stays inactive until applied
    wr(`PTP_OFF_PULSE_FORM, 32'h2);
    rdc(`PTP_OFF_STATUS, 32'h2, 32'h7FFA);
    rdc(`PTP_OFF_PULSE_FORM, 32'h2);
    pulses(12'h000, 1'b0, 16);
    rdc(`PTP_OFF_STATUS, 32'h0, 32'h2);
    pulses(12'h010, 1'b1, 16);
    pulses(12'h001, 1'b0, 16);
    pulses(12'h002, 1'b0, 16);
    pulses(12'h202, 1'b1, 80);
    // encoder re-output in direct, division and gear modes
    enc(2'h3, 16'h1, 16'h1, 8, 1'b0, 8);
    enc(2'h3, 16'h1, 16'h1, 8, 1'b1, 8);
    enc(2'h1, 16'h2, 16'h1, 16, 1'b0, 8);
    enc(2'h0, 16'h8000, 16'h1, 32, 1'b0, 8);
    enc(2'h3, 16'h3, 16'h0, 2, 1'b0, 6);
    end_sim();
  end
endmodule : ptp_top_test
`default_nettype wire
